// ### rtl/dtsio_pkg.sv
// Shared constants and types for the dual transmitter supervisor logic
package dtsio_pkg;
	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] OFF_STATUS = 8'h6E;
	localparam logic [7:0] OFF_PART_ID = 8'h86;
	localparam logic [7:0] OFF_SI_VER = 8'h87;
	localparam logic [7:0] OFF_CFG_A = 8'h88;
	localparam logic [7:0] OFF_CFG_B = 8'h89;
	localparam logic [7:0] OFF_FSD_CFG = 8'h8A;
	localparam logic [7:0] OFF_SLV_SEL = 8'h8B;
	localparam logic [7:0] OFF_ALM_EN_A = 8'hF8;
	localparam logic [7:0] OFF_ALM_EN_B = 8'hFC;
	localparam logic [7:0] OFF_OFFSET_BASE = 8'hF8;
	// Arbitrary neutral identity values
	localparam logic [7:0] PART_ID_VAL = 8'h5A;
	localparam logic [7:0] SI_VER_VAL = 8'h01;
	// ************************************************************
	// Status byte fields
	// ************************************************************
	localparam int ST_NRDY = 0;
	localparam int ST_RSOUT = 3;
	localparam int ST_RSIN = 4;
	localparam int ST_GPIN = 5;
	localparam int ST_SDIS_A = 6;
	localparam int ST_SDIS_B = 7;
	// Config A fields
	localparam int CA_RS_INV = 0;
	// Config B fields
	localparam int CB_GO_FORCE = 0;
	localparam int CB_GO_FVAL = 1;
	localparam int CB_GO_INV = 2;
	localparam int CB_FLT_LATCH = 3;
	// Fast shutdown config fields
	localparam int FS_EN_FLT = 0;
	localparam int FS_EN_LOWP = 1;
	// ************************************************************
	// Defaults and widths
	// ************************************************************
	localparam logic [7:0] SLV_DEFAULT = 8'hA2;
	localparam int DAC_W = 10;
	localparam int NCH = 4;
	localparam logic [9:0] DAC_MAX = 10'h3FF;
	localparam int OFFSET_MUL_SH = 2;
	localparam int TEMP_STEP_C = 2;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ = 200;
	localparam int READY_US = 500;
	localparam int READY_CYC = READY_US * CLK_MHZ;
	localparam int RECOV_US = 100;
	localparam int RECOV_CYC = RECOV_US * CLK_MHZ;
	typedef enum logic [3:0] {
		DTS_OFF = 4'h1,
		DTS_RECALL = 4'h2,
		DTS_WAIT = 4'h4,
		DTS_RUN = 4'h8
	} dtsio_pwr_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dtsio_bus_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [9:0] fine;
		logic [7:0] coarse;
	} dtsio_lut_t;
endpackage

// ### rtl/dtsio_pdm.sv
// First-order pulse-density modulator for one 10-bit output
`timescale 1ns/1ps
module dtsio_pdm
	import dtsio_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [DAC_W-1:0] code,
	output logic bitOut
);
	typedef struct packed {
		logic [DAC_W:0] acc;
		logic out;
	} dtsio_pdm_t;
	dtsio_pdm_t s_q, s_d;
	always_comb begin
		logic [DAC_W:0] sum;
		sum = {1'b0, s_q.acc[DAC_W-1:0]} + {1'b0, code};
		s_d.acc = sum;
		s_d.out = sum[DAC_W];
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign bitOut = s_q.out;
endmodule

// ### rtl/dtsio_top.sv
// Supervisory logic: supply sequencing, PDM outputs, digital I/O, fault
`timescale 1ns/1ps
// What this block does
// - Two thresholds; below analog, outputs off.
// - Analog threshold reached: recall settings, enable.
// - Analog lost, digital kept: keep settings.
// - Analog regained: resume without recall.
// - Digital lost: defaults, recall next time.
// - Not-ready flag clears within 500 us.
// - Not-ready flag readable in status byte.
// - Default slave address until recall done.
// - Four 10-bit PDM outputs, manual or lookup.
// - PDM outputs high impedance before init.
// - Fine table plus coarse offset table.
// - Code is fine plus four times coarse.
// - Reload code after each temperature conversion.
// - Input levels readable in status byte.
// - General output with force and invert.
// - Rate-select output from input pin or software bit, invertible.
// - Disable outputs combine faults, pins, shutdown.
// - Disable pulse extended; low alarms held.
// - Low-power alarm no shutdown during extension.
// - Disable outputs high impedance below analog.
// - Fault output gated, latched or not.
// - Fixed identity and version on reads.
// - Disable release reloads present-temperature code.
// - Fast comparators reach shutdown through masks.
module dtsio_top
	import dtsio_pkg::*;
#(
	parameter int READY_CYCLES = READY_CYC,
	parameter int RECOV_CYCLES = RECOV_CYC
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic supplyAboveDigital,
	input wire logic supplyAboveAnalog,
	input wire logic recallDone,
	output logic recallReq,
	input wire dtsio_bus_t regBus,
	output logic [7:0] regRdata,
	input wire logic [7:0] nvConfigA,
	input wire logic [7:0] nvConfigB,
	input wire logic [7:0] nvFastCfg,
	input wire logic [7:0] nvSlaveSel,
	input wire logic [7:0] nvAlarmEnA,
	input wire logic [7:0] nvAlarmEnB,
	output logic [7:0] slaveAddress,
	input wire logic tempConvDone,
	input wire logic [NCH-1:0] lutMode,
	input wire logic [NCH*DAC_W-1:0] manualCode,
	input wire logic [NCH*DAC_W-1:0] lutFine,
	input wire logic [NCH*8-1:0] lutCoarse,
	input wire logic [NCH-1:0] offLevelRef,
	output logic [NCH-1:0] pdmOut,
	output logic [NCH-1:0] pdmOe,
	input wire logic generalInput,
	input wire logic rateSelectIn,
	output logic generalOutputOut,
	output logic generalOutputOe,
	output logic rateSelectOutOut,
	output logic rateSelectOutOe,
	input wire logic faultInA,
	input wire logic faultInB,
	input wire logic disableInA,
	input wire logic disableInB,
	input wire logic [1:0] quickTripHigh,
	input wire logic [1:0] lowPowerAlarm,
	input wire logic [1:0] quickTripMask,
	input wire logic [7:0] adcAlarms,
	input wire logic [7:0] adcWarnings,
	output logic [1:0] disableOut,
	output logic [1:0] disableOe,
	output logic [1:0] fastShutdown,
	output logic [1:0] lowAlarmHold,
	output logic transmitFaultOut,
	output logic transmitFaultOe
);
	typedef struct packed {
		dtsio_pwr_t pwr;
		logic recalled;
		logic [31:0] rdyCnt;
		logic notReady;
		logic [7:0] status;
		logic [7:0] cfgA;
		logic [7:0] cfgB;
		logic [7:0] fsCfg;
		logic [7:0] slvSel;
		logic [7:0] almEnA;
		logic [7:0] almEnB;
		logic [1:0][31:0] extCnt;
		logic [1:0] disPrev;
		logic [NCH-1:0][DAC_W-1:0] code;
		logic faultLatch;
		logic [7:0] rdata;
		logic [1:0] dOut;
		logic gOut;
		logic rOut;
		logic tOut;
	} dtsio_state_t;
	dtsio_state_t s_q, s_d;
	logic analogOn;
	logic [1:0] disIn;
	logic [1:0] disEff;
	logic [1:0] extending;
	logic [1:0] fsd;
	logic [NCH-1:0][DAC_W-1:0] lutCode;
	logic [NCH-1:0][DAC_W-1:0] pickCode;
	logic faultRaw;
	assign analogOn = supplyAboveAnalog && (s_q.pwr == DTS_WAIT || s_q.pwr == DTS_RUN);
	assign disIn = {disableInB, disableInA};
	// ************************************************************
	// Lookup code per channel
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : gCh
			logic [DAC_W+1:0] sum;
			assign sum = {2'b00, lutFine[gi*DAC_W +: DAC_W]}
				+ {2'b00, lutCoarse[gi*8 +: 8], 2'b00};
			assign lutCode[gi] = (sum > {2'b00, DAC_MAX}) ? DAC_MAX : sum[DAC_W-1:0];
			assign pickCode[gi] = lutMode[gi] ? lutCode[gi] : manualCode[gi*DAC_W +: DAC_W];
			dtsio_pdm uPdm (
				.clk(clk),
				.resetn(resetn),
				.code(s_q.code[gi]),
				.bitOut(pdmOut[gi])
			);
			assign pdmOe[gi] = analogOn && !s_q.notReady
				&& !(disEff[gi % 2] && !offLevelRef[gi]);
		end
	endgenerate
	// ************************************************************
	// Disable and fast shutdown
	// ************************************************************
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			disEff[c] = disIn[c] || s_q.status[ST_SDIS_A + c];
			extending[c] = (s_q.extCnt[c] != 32'd0);
			// Masked quick trips; low power gated by extension
			fsd[c] = (quickTripHigh[c] && quickTripMask[c])
				|| (lowPowerAlarm[c] && s_q.fsCfg[FS_EN_LOWP] && !extending[c])
				|| ((c == 0 ? faultInA : faultInB) && s_q.fsCfg[FS_EN_FLT]);
		end
	end
	assign faultRaw = |(adcAlarms & s_q.almEnA) || |(adcWarnings & s_q.almEnB)
		|| |quickTripHigh || |lowPowerAlarm || faultInA || faultInB || |disEff;
	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		recallReq = 1'b0;
		// Power sequencing reset to defaults below digital
		case (s_q.pwr)
			DTS_OFF: begin
				if (supplyAboveAnalog) begin
					s_d.pwr = s_q.recalled ? DTS_WAIT : DTS_RECALL;
				end
			end
			DTS_RECALL: begin
				recallReq = 1'b1;
				if (recallDone) begin
					s_d.cfgA = nvConfigA;
					s_d.cfgB = nvConfigB;
					s_d.fsCfg = nvFastCfg;
					s_d.slvSel = nvSlaveSel;
					s_d.almEnA = nvAlarmEnA;
					s_d.almEnB = nvAlarmEnB;
					s_d.recalled = 1'b1;
					s_d.pwr = DTS_WAIT;
					s_d.rdyCnt = 32'd0;
				end
			end
			DTS_WAIT: begin
				if (s_q.rdyCnt >= 32'(READY_CYCLES - 1)) begin
					s_d.pwr = DTS_RUN;
					s_d.notReady = 1'b0;
				end else begin
					s_d.rdyCnt = s_q.rdyCnt + 32'd1;
				end
			end
			DTS_RUN: ;
			default: s_d.pwr = DTS_OFF;
		endcase
		// Analog lost: keep settings resume without recall
		if (!supplyAboveAnalog && s_q.pwr != DTS_OFF) begin
			s_d.pwr = DTS_OFF;
			s_d.notReady = 1'b1;
			s_d.rdyCnt = 32'd0;
		end
		// Register writes, held off until settings are loaded
		if (regBus.wr && s_q.recalled) begin
			case (regBus.addr)
				OFF_STATUS: begin
					s_d.status[ST_SDIS_B] = regBus.wdata[ST_SDIS_B];
					s_d.status[ST_SDIS_A] = regBus.wdata[ST_SDIS_A];
					s_d.status[ST_RSOUT] = regBus.wdata[ST_RSOUT];
				end
				OFF_CFG_A: s_d.cfgA = regBus.wdata;
				OFF_CFG_B: s_d.cfgB = regBus.wdata;
				OFF_FSD_CFG: s_d.fsCfg = regBus.wdata;
				OFF_SLV_SEL: s_d.slvSel = regBus.wdata;
				OFF_ALM_EN_A: s_d.almEnA = regBus.wdata;
				OFF_ALM_EN_B: s_d.almEnB = regBus.wdata;
				default: ;
			endcase
		end
		s_d.status[ST_GPIN] = generalInput;
		s_d.status[ST_RSIN] = rateSelectIn;
		s_d.status[ST_NRDY] = s_d.notReady;
		for (int c = 0; c < 2; c++) begin
			s_d.disPrev[c] = disEff[c];
			if (disEff[c]) begin
				s_d.extCnt[c] = 32'(RECOV_CYCLES);
			end else if (s_q.extCnt[c] != 32'd0) begin
				s_d.extCnt[c] = s_q.extCnt[c] - 32'd1;
			end
		end
		// Reload on conversion and on disable release
		for (int n = 0; n < NCH; n++) begin
			if (tempConvDone || (s_q.disPrev[n % 2] && !disEff[n % 2]) || !lutMode[n]) begin
				s_d.code[n] = pickCode[n];
			end
			if (disEff[n % 2]) begin
				s_d.code[n] = offLevelRef[n] ? DAC_MAX : '0;
			end
		end
		if (faultRaw) begin
			s_d.faultLatch = 1'b1;
		end else if (!s_q.cfgB[CB_FLT_LATCH] || (regBus.rd && regBus.addr == OFF_STATUS)) begin
			s_d.faultLatch = 1'b0;
		end
		s_d.tOut = s_d.faultLatch;
		// Disable combines pins, software bits, shutdown
		for (int c = 0; c < 2; c++) begin
			s_d.dOut[c] = disEff[c] || fsd[c] || (c == 0 ? faultInA : faultInB);
		end
		s_d.gOut = (s_q.cfgB[CB_GO_FORCE] ? s_q.cfgB[CB_GO_FVAL] : generalInput)
			^ s_q.cfgB[CB_GO_INV];
		s_d.rOut = (s_q.status[ST_RSOUT] | rateSelectIn) ^ s_q.cfgA[CA_RS_INV];
		// Identity reads; shadowed bytes read zero until recalled
		case (regBus.addr)
			OFF_STATUS: s_d.rdata = s_d.status;
			OFF_PART_ID: s_d.rdata = PART_ID_VAL;
			OFF_SI_VER: s_d.rdata = SI_VER_VAL;
			OFF_CFG_A: s_d.rdata = s_q.cfgA;
			OFF_CFG_B: s_d.rdata = s_q.cfgB;
			OFF_FSD_CFG: s_d.rdata = s_q.fsCfg;
			OFF_SLV_SEL: s_d.rdata = s_q.slvSel;
			OFF_ALM_EN_A: s_d.rdata = s_q.almEnA;
			OFF_ALM_EN_B: s_d.rdata = s_q.almEnB;
			default: s_d.rdata = 8'h00;
		endcase
	end
	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.pwr <= DTS_OFF;
			s_q.notReady <= 1'b1;
			s_q.status <= 8'h01;
		end else if (!supplyAboveDigital) begin
			// Below digital threshold: back to defaults
			s_q <= '0;
			s_q.pwr <= DTS_OFF;
			s_q.notReady <= 1'b1;
			s_q.status <= 8'h01;
		end else begin
			s_q <= s_d;
		end
	end
	// ************************************************************
	// Outputs
	// ************************************************************
	assign regRdata = s_q.rdata;
	assign slaveAddress = s_q.recalled ? s_q.slvSel : SLV_DEFAULT;
	assign fastShutdown = fsd & {2{analogOn}};
	assign lowAlarmHold = extending;
	// Disable outputs float below analog threshold
	assign disableOut = s_q.dOut;
	assign disableOe = {2{analogOn}};
	assign generalOutputOut = 1'b0;
	assign generalOutputOe = analogOn && !s_q.gOut;
	assign rateSelectOutOut = 1'b0;
	assign rateSelectOutOe = analogOn && !s_q.rOut;
	assign transmitFaultOut = 1'b0;
	assign transmitFaultOe = analogOn && s_q.tOut;
endmodule

// ### verif/dtsio_top_asserts.sv
// Port-level assertions for the supervisor top
`timescale 1ns/1ps
module dtsio_top_asserts
	import dtsio_pkg::*;
#(
	parameter int READY_CYCLES = 20,
	parameter int RECOV_CYCLES = 10
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic supplyAboveDigital,
	input wire logic supplyAboveAnalog,
	input wire dtsio_bus_t regBus,
	input wire logic [7:0] regRdata,
	input wire logic [7:0] slaveAddress,
	input wire logic faultInA,
	input wire logic faultInB,
	input wire logic disableInA,
	input wire logic [1:0] quickTripHigh,
	input wire logic [NCH-1:0] pdmOe,
	input wire logic generalOutputOut,
	input wire logic rateSelectOutOut,
	input wire logic transmitFaultOut,
	input wire logic transmitFaultOe,
	input wire logic [1:0] disableOut,
	input wire logic [1:0] disableOe,
	input wire logic [1:0] fastShutdown,
	input wire logic [1:0] lowAlarmHold
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// Extension must outlive the pin pulse by several cycles
	sequence extRun;
		lowAlarmHold[0] [*4];
	endsequence
	a_oe_below_analog: assert property (
		!supplyAboveAnalog && !$past(supplyAboveAnalog) |-> pdmOe == '0 && disableOe == '0)
		else $error("outputs driven below analog supply");
	a_pdm_enable_cause: assert property ($rose(pdmOe[0]) |-> supplyAboveAnalog)
		else $error("modulator enabled without analog supply");
	a_default_addr: assert property (!supplyAboveDigital |=> slaveAddress == SLV_DEFAULT)
		else $error("slave address not default after supply loss");
	a_id_read: assert property (
		supplyAboveDigital && regBus.rd && regBus.addr == OFF_PART_ID |=> regRdata == PART_ID_VAL)
		else $error("part identifier read wrong");
	a_od_drive_low: assert property (
		generalOutputOut == 1'b0 && rateSelectOutOut == 1'b0 && transmitFaultOut == 1'b0)
		else $error("open drain output drives high");
	a_dis_pin: assert property (
		supplyAboveAnalog && $past(supplyAboveAnalog) && disableInA |=> disableOut[0])
		else $error("disable pin not passed to output");
	a_ext_hold: assert property ($fell(disableInA) && supplyAboveAnalog |-> ##[0:2] extRun)
		else $error("disable extension too short");
	a_lowp_no_fsd: assert property (
		lowAlarmHold[0] && !quickTripHigh[0] && !faultInA && !faultInB && !disableInA
		|-> !fastShutdown[0])
		else $error("shutdown raised during extension");
	a_tfault_pin: assert property (supplyAboveAnalog && faultInA |-> ##[0:3] transmitFaultOe)
		else $error("fault input not on fault output");
endmodule

// ### verif/dtsio_partner.sv
// Nonvolatile recall source and pulled-up open-drain pins
`timescale 1ns/1ps
module dtsio_partner
	import dtsio_pkg::*;
#(
	parameter logic [7:0] NV_A = 8'h01,
	parameter logic [7:0] NV_SLV = 8'hB4
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic recallReq,
	input wire logic slowMode,
	output logic recallDone,
	output logic [7:0] nvConfigA,
	output logic [7:0] nvConfigB,
	output logic [7:0] nvFastCfg,
	output logic [7:0] nvSlaveSel,
	output logic [7:0] nvAlarmEnA,
	output logic [7:0] nvAlarmEnB,
	input wire logic generalOutputOe,
	input wire logic rateSelectOutOe,
	input wire logic transmitFaultOe,
	output logic generalPin,
	output logic ratePin,
	output logic faultPin
);
	int waitCnt;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			recallDone <= 1'b0;
			waitCnt <= 0;
		end else begin
			recallDone <= 1'b0;
			if (recallReq && !recallDone) begin
				waitCnt <= waitCnt + 1;
				if (waitCnt >= (slowMode ? 7 : 1)) begin
					recallDone <= 1'b1;
					waitCnt <= 0;
				end
			end
		end
	end
	// Stale data outside the recall pulse, so a late sample shows up
	assign nvConfigA = recallDone ? NV_A : ~NV_A;
	assign nvConfigB = recallDone ? 8'h00 : 8'hFF;
	assign nvFastCfg = recallDone ? 8'h00 : 8'hFF;
	assign nvSlaveSel = recallDone ? NV_SLV : ~NV_SLV;
	assign nvAlarmEnA = recallDone ? 8'h00 : 8'hFF;
	assign nvAlarmEnB = recallDone ? 8'h00 : 8'hFF;
	// Pull-ups on the module pins
	assign generalPin = !generalOutputOe;
	assign ratePin = !rateSelectOutOe;
	assign faultPin = !transmitFaultOe;
endmodule

// ### verif/dtsio_top_tb_top.sv
// Self-checking bench for the supervisor top level
`timescale 1ns/1ps
module dtsio_top_tb_top
	import dtsio_pkg::*;
;
	localparam int RDY = 20;
	localparam int REC = 10;
	localparam logic [7:0] NV_A = 8'h01;
	localparam logic [7:0] NV_SLV = 8'hB4;
	logic clk = 0, resetn = 0, supplyAboveDigital = 0, supplyAboveAnalog = 0, slowMode = 0;
	logic recallDone, recallReq, generalPin, ratePin, faultPin, tempConvDone = 0;
	logic generalInput = 0, rateSelectIn = 0;
	logic [1:0] dis = '0, flt = '0;
	wire disableInA = dis[0], disableInB = dis[1], faultInA = flt[0], faultInB = flt[1];
	dtsio_bus_t regBus = '0;
	logic [7:0] regRdata, slaveAddress, nvConfigA, nvConfigB, nvFastCfg, nvSlaveSel;
	logic [7:0] nvAlarmEnA, nvAlarmEnB, adcAlarms = '0, adcWarnings = '0;
	logic generalOutputOut, generalOutputOe, rateSelectOutOut, rateSelectOutOe;
	logic transmitFaultOut, transmitFaultOe;
	logic [NCH-1:0] lutMode = '0, offLevelRef = '0, pdmOut, pdmOe;
	logic [NCH*DAC_W-1:0] manualCode = '0, lutFine = '0;
	logic [NCH*8-1:0] lutCoarse = '0;
	logic [1:0] quickTripHigh = '0, lowPowerAlarm = '0, quickTripMask = '0;
	logic [1:0] disableOut, disableOe, fastShutdown, lowAlarmHold;
	int num_errors = 0, checks = 0, seed = 42113, cnt;
	always #2.5 clk = ~clk;
	dtsio_top #(.READY_CYCLES(RDY), .RECOV_CYCLES(REC)) dtsio_top_i (.*);
	dtsio_partner #(.NV_A(NV_A), .NV_SLV(NV_SLV)) dtsio_partner_i (.*);
	// *****************
	// Helpers
	// *****************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		regBus <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		#1 q = regRdata;
		@(posedge clk);
		regBus <= '0;
		// Let registered outputs of the last edge settle before callers look
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] q;
		acc(1'b0, a, 8'h00, q);
		check(q & m, e & m);
	endtask
	task automatic power_up();
		logic [7:0] q;
		int n;
		@(posedge clk);
		supplyAboveDigital <= 1'b1;
		supplyAboveAnalog <= 1'b1;
		q = 8'h01;
		for (n = 0; n < 14 && q[0] !== 1'b0; n++) acc(1'b0, OFF_STATUS, 8'h00, q);
		check(q[0], 1'b0);
	endtask
	function automatic int exp_code(input int f, input int c);
		return (f + 4 * c > 1023) ? 1023 : f + 4 * c;
	endfunction
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
	// *****************
	// Tests
	// *****************
	initial begin
		logic [7:0] d, s;
		logic [9:0] f, c;
		int k;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk) supplyAboveDigital <= 1'b1;
		rdc(OFF_STATUS, 8'h01, 8'h01);
		rdc(OFF_CFG_A, 8'h00, 8'hFF);
		check(slaveAddress, SLV_DEFAULT);
		rdc(OFF_SI_VER, SI_VER_VAL, 8'hFF);
		$display("below analog done");
		power_up();
		rdc(OFF_CFG_A, NV_A, 8'hFF);
		check(slaveAddress, NV_SLV);
		for (k = 0; k < 5; k++) begin
			s = k == 0 ? OFF_CFG_B : k == 1 ? OFF_FSD_CFG : k == 2 ? OFF_ALM_EN_A :
				k == 3 ? OFF_ALM_EN_B : OFF_SLV_SEL;
			d = $random(seed);
			wr(s, d);
			rdc(s, d, 8'hFF);
		end
		check(slaveAddress, d);
		wr(OFF_PART_ID, ~PART_ID_VAL);
		rdc(OFF_PART_ID, PART_ID_VAL, 8'hFF);
		rdc(8'h90, 8'h00, 8'hFF);
		wr(OFF_FSD_CFG, 8'h00);
		$display("registers done");
		for (k = 0; k < 32; k++) begin
			@(posedge clk);
			rateSelectIn <= k[0];
			generalInput <= k[1];
			wr(OFF_STATUS, {4'h0, k[2], 3'h0});
			wr(OFF_CFG_A, {7'h00, k[3]});
			wr(OFF_CFG_B, {5'h00, k[4], 2'b00});
			rdc(OFF_STATUS, {2'b00, k[1], k[0], k[2], 3'h0}, 8'hF8);
			check(ratePin, (k[2] | k[0]) ^ k[3]);
			check(generalPin, k[1] ^ k[4]);
			wr(OFF_CFG_B, {6'h00, k[0], 1'b1});
			check(generalPin, k[0]);
		end
		$display("pins done");
		for (k = 0; k < 2; k++) begin
			wr(OFF_CFG_B, 8'h00);
			@(posedge clk) dis[k] <= 1'b1;
			repeat (3) @(posedge clk);
			check(disableOut[k], 1'b1);
			check(transmitFaultOe, 1'b1);
			dis[k] <= 1'b0;
			repeat (2) @(posedge clk);
			check(lowAlarmHold[k], 1'b1);
			repeat (REC + 5) @(posedge clk);
			check({lowAlarmHold[k], disableOut[k]}, 2'b00);
			wr(OFF_STATUS, k ? 8'h80 : 8'h40);
			check(disableOut[k], 1'b1);
			wr(OFF_STATUS, 8'h00);
			wr(OFF_CFG_B, 8'h08);
			flt[k] <= 1'b1;
			repeat (4) @(posedge clk);
			flt[k] <= 1'b0;
			repeat (4) @(posedge clk);
			check(faultPin, 1'b0);
			rdc(OFF_STATUS, 8'h00, 8'h00);
			repeat (2) @(posedge clk);
			check(faultPin, 1'b1);
		end
		// Low-power alarm must wait out the extension before shutting down
		wr(OFF_FSD_CFG, 8'h02);
		@(posedge clk) dis <= 2'b01;
		@(posedge clk) dis <= 2'b00;
		lowPowerAlarm <= 2'b01;
		repeat (3) @(posedge clk);
		check(fastShutdown[0], 1'b0);
		repeat (REC + 2) @(posedge clk);
		check(fastShutdown[0], 1'b1);
		lowPowerAlarm <= 2'b00;
		quickTripHigh <= 2'b10;
		quickTripMask <= 2'b10;
		@(posedge clk);
		@(posedge clk);
		check(fastShutdown, 2'b10);
		quickTripMask <= 2'b00;
		@(posedge clk);
		@(posedge clk);
		check(fastShutdown, 2'b00);
		quickTripHigh <= 2'b00;
		wr(OFF_FSD_CFG, 8'h00);
		$display("disable and fault done");
		for (k = 0; k < 3; k++) begin
			f = k == 1 ? 10'h3FF : 10'($random(seed)) & 10'h0FF;
			c = k == 1 ? 10'h0FF : 10'($random(seed)) & 10'h03F;
			@(posedge clk);
			lutMode <= {3'b000, k != 2};
			lutFine <= {30'($random(seed)), f};
			lutCoarse <= {24'($random(seed)), c[7:0]};
			manualCode <= {30'($random(seed)), f};
			offLevelRef <= 4'($random(seed));
			tempConvDone <= 1'b1;
			@(posedge clk) tempConvDone <= 1'b0;
			repeat (4) @(posedge clk);
			cnt = 0;
			repeat (1024) begin
				@(posedge clk);
				#1 cnt += pdmOut[0];
			end
			check(pdmOe[0], 1'b1);
			check(cnt - (k == 2 ? f : exp_code(f, c)) + 2 inside {[0:4]}, 1'b1);
		end
		$display("modulator done");
		@(posedge clk) supplyAboveAnalog <= 1'b0;
		repeat (3) @(posedge clk);
		check({pdmOe, disableOe}, 6'h00);
		rdc(OFF_STATUS, 8'h01, 8'h01);
		rdc(OFF_CFG_A, 8'h01, 8'hFF);
		@(posedge clk) supplyAboveAnalog <= 1'b1;
		cnt = 0;
		repeat (10) begin
			@(posedge clk);
			#1 cnt += recallReq;
		end
		check(cnt, 0);
		power_up();
		@(posedge clk);
		supplyAboveDigital <= 1'b0;
		supplyAboveAnalog <= 1'b0;
		repeat (2) @(posedge clk);
		check(slaveAddress, SLV_DEFAULT);
		supplyAboveDigital <= 1'b1;
		rdc(OFF_CFG_A, 8'h00, 8'hFF);
		slowMode <= 1'b1;
		power_up();
		rdc(OFF_CFG_A, NV_A, 8'hFF);
		$display("supply sequencing done");
		report_and_stop();
	end
endmodule
bind dtsio_top dtsio_top_asserts #(.READY_CYCLES(READY_CYCLES), .RECOV_CYCLES(RECOV_CYCLES))
	dtsio_top_asserts_i (.*);
